// ==== hw/asc_pkg.sv ====
package asc_pkg;
  // register word offsets (byte addresses on the plain port)
  localparam logic [3:0] ADDR_CTL2      = 4'h2; // other control register
  localparam logic [3:0] ADDR_SEQ_CTRL  = 4'h3; // seq_ctrl_reg
  localparam logic [3:0] ADDR_CTL4      = 4'h4; // other control register
  localparam logic [3:0] ADDR_START     = 4'h5; // sequence_start_reg
  localparam logic [3:0] ADDR_STATUS0   = 4'h6; // conv_status_reg_zero
  localparam logic [3:0] ADDR_FLAGS     = 4'h8; // conv_done_flag bits
  localparam logic [3:0] ADDR_IRQ_STAT  = 4'h9; // sticky event status
  localparam logic [3:0] ADDR_IRQ_MASK  = 4'ha; // event mask
  localparam logic [3:0] ADDR_OPTS      = 4'hb; // scan and quick clear
  localparam logic [3:0] ADDR_RESULT0   = 4'h0; // result window base (hi)
  localparam logic [3:0] ADDR_RES_SPACE = 4'h1; // address bit 4 selects result
  // field positions of seq_ctrl_reg
  localparam int SEQ_LEN_LSB   = 3;
  localparam int RING_BIT      = 2;
  localparam int HALT_SEL_LSB  = 0;
  // reset value: only seq_len_bit2 set, length 4
  localparam logic [7:0] SEQ_CTRL_RST = 8'h20;
  localparam logic [6:0] SEQ_CTRL_MASK = 7'h7f;
  // debug halt selections
  localparam logic [1:0] HALT_NONE   = 2'h0;
  localparam logic [1:0] HALT_RSVD   = 2'h1;
  localparam logic [1:0] HALT_FINISH = 2'h2;
  localparam logic [1:0] HALT_NOW    = 2'h3;
  // option bits
  localparam int OPT_SCAN  = 0;
  localparam int OPT_QUICK = 1;
  // interrupt event bits
  localparam int EV_SEQ_DONE = 0;
  localparam int EV_ABORT    = 1;
  localparam int EV_OVERRUN  = 2;
  localparam int EV_NUM      = 3;
  // sequencer states, one-hot
  typedef enum logic [2:0] {
    ASC_IDLE = 3'h1,
    ASC_CONV = 3'h2,
    ASC_HALT = 3'h4
  } asc_state_t;
endpackage

// ==== hw/asc_len_decode.sv ====
`timescale 1ns/1ps
// turns the four-bit length field into a conversion count
module asc_len_decode (
  input  wire logic [3:0] len_code,  // seq_len_bit3..0
  output logic      [3:0] len_count  // conversions per sequence, 1 to 8
);
  always_comb begin
    // top bit set or all zero both give eight
    if (len_code[3] || len_code == 4'h0) begin
      len_count = 4'h8;
    end else begin
      len_count = len_code;
    end
  end
endmodule

// ==== hw/asc_seq_ctrl.sv ====
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module asc_seq_ctrl #(
  parameter int NUM_RESULTS = 8,  // depth of the result file
  parameter int RES_W       = 10  // result width
) (
  input  wire logic             mclk,        // bus clock
  input  wire logic             rstn,        // async reset, active low
  input  wire logic [4:0]       addr,        // register address
  input  wire logic [7:0]       wdata,       // write data
  input  wire logic             wr,          // write strobe
  input  wire logic             rd,          // read strobe
  output logic      [7:0]       rdata,       // read data, cycle after rd
  input  wire logic             debug_freeze,// breakpoint freeze from debug
  input  wire logic             ext_trig,    // external trigger level
  output logic                  conv_start,  // pulse: core begins a conversion
  output logic                  conv_abort,  // pulse: core drops its work
  output logic                  conv_hold,   // core pauses mid-conversion
  input  wire logic             conv_done,   // core finished one conversion
  input  wire logic [RES_W-1:0] conv_data,   // result from the core
  output logic      [2:0]       result_slot, // slot of conversion in progress
  output logic                  seq_active,  // sequence running
  output logic                  irq          // level interrupt
);
  // register map on the plain port (addr[4] clear):
  //   0x2, 0x4  other control registers, writes only abort
  //   0x3       seq_ctrl_reg: length 6-3, ring 2, halt select 1-0
  //   0x5       sequence_start_reg: any write starts a sequence
  //   0x6       status: sequence complete 7, slot counter 2-0
  //   0x8       conv_done_flag per result register
  //   0x9       sticky events, write one to clear
  //   0xa       event mask, same layout as the events
  //   0xb       options: quick clear 1, continuous scan 0
  // addr[4] set reads the top eight bits of result addr[2:0]
  //
  // hazards a user must know:
  //   ring mode is meant for scanning or triggered starts; a single
  //   sequence in ring mode leaves the slot counter mid-file
  //   a write to 0x2 to 0x5 drops any sequence in flight, so
  //   reprogramming while scanning loses the conversion under way
  //   the halt-now freeze holds the core mid-conversion; a long
  //   freeze may spoil that result
  //   reserved halt code 01 acts as keep converting
  //   the overrun event flags a result stored over an unread one
  initial begin
    // the slot counter is three bits wide
    if (NUM_RESULTS != 8 || RES_W < 8 || RES_W > 16) begin
      $error("asc_seq_ctrl: unsupported parameters");
    end
  end

  // event count, declared before the vectors that use it
  localparam int EV_NUM_W = asc_pkg::EV_NUM;
  // local names for the sequencer states
  localparam asc_pkg::asc_state_t ASC_IDLE = asc_pkg::ASC_IDLE;
  localparam asc_pkg::asc_state_t ASC_CONV = asc_pkg::ASC_CONV;
  localparam asc_pkg::asc_state_t ASC_HALT = asc_pkg::ASC_HALT;

  // control state
  logic [6:0]               seq_ctrl;     // seq_ctrl_reg, bit 7 absent
  logic [1:0]               opts;         // scan and quick clear options
  logic [EV_NUM_W-1:0]      ev_stat;      // sticky events
  logic [EV_NUM_W-1:0]      ev_mask;      // event enables
  logic [NUM_RESULTS-1:0]   done_flag;    // conv_done_flag per slot
  logic [NUM_RESULTS-1:0]   stat_seen;    // status read armed clear
  logic [RES_W-1:0]         result_mem [NUM_RESULTS]; // result file
  logic [2:0]               slot;         // result_slot_count
  logic [3:0]               pos;          // conversions done this sequence
  logic                     scf;          // sequence complete flag
  asc_pkg::asc_state_t      state;        // sequencer state
  logic [1:0]               trig_sync;    // external trigger synchroniser
  logic [1:0]               frz_sync;     // freeze synchroniser
  logic                     trig_prev;    // trigger edge history

  logic [3:0] len_count;                  // decoded length
  logic       wr_seq;                     // write to seq_ctrl_reg
  logic       wr_ctl;                     // write to any control register
  logic       wr_start;                   // write to sequence_start_reg
  logic       res_acc;                    // result register access
  logic [2:0] res_idx;                    // result register addressed
  logic       trig_rise;                  // synchronised trigger edge
  logic       frozen;                     // synchronised freeze
  logic       last_conv;                  // this completion ends sequence
  logic       take;                       // a result is being stored
  logic [EV_NUM_W-1:0] ev_set;            // events this cycle

  asc_len_decode u_len (
    .len_code  (seq_ctrl[asc_pkg::SEQ_LEN_LSB +: 4]),
    .len_count (len_count)
  );

  // decode of the plain register port
  assign wr_seq   = wr && addr == {1'b0, asc_pkg::ADDR_SEQ_CTRL};
  assign wr_start = wr && addr == {1'b0, asc_pkg::ADDR_START};
  assign wr_ctl   = wr && !addr[4] && addr[3:0] >= asc_pkg::ADDR_CTL2 &&
                    addr[3:0] <= asc_pkg::ADDR_START;
  assign res_acc  = (wr || rd) && addr[4];
  assign res_idx  = addr[2:0];
  assign trig_rise = trig_sync[1] && !trig_prev;
  assign frozen    = frz_sync[1];
  assign take      = state == ASC_CONV && conv_done;
  assign last_conv = take && (pos + 4'h1 == len_count);

  // two-flop synchronisers for the pin inputs
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      trig_sync <= 2'h0;
      frz_sync  <= 2'h0;
      trig_prev <= 1'b0;
    end else begin
      trig_sync <= {trig_sync[0], ext_trig};
      frz_sync  <= {frz_sync[0], debug_freeze};
      trig_prev <= trig_sync[1];
    end
  end

  // seq_ctrl_reg and option register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      seq_ctrl <= asc_pkg::SEQ_CTRL_RST[6:0];
      opts     <= 2'h0;
    end else begin
      if (wr_seq) begin
        seq_ctrl <= wdata[6:0] & asc_pkg::SEQ_CTRL_MASK;
      end
      if (wr && addr == {1'b0, asc_pkg::ADDR_OPTS}) begin
        opts <= wdata[1:0];
      end
    end
  end

  // sequencer: start, conversion, halt
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state      <= ASC_IDLE;
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
      conv_hold  <= 1'b0;
      seq_active <= 1'b0;
      pos        <= 4'h0;
    end else begin
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
      if (wr_ctl) begin
        // any control write drops the sequence; only start restarts
        conv_abort <= state != ASC_IDLE;
        pos        <= 4'h0;
        if (wr_start) begin
          state      <= ASC_CONV;
          conv_start <= 1'b1;
          seq_active <= 1'b1;
        end else begin
          state      <= ASC_IDLE;
          seq_active <= 1'b0;
        end
        conv_hold <= 1'b0;
      end else begin
        case (state)
          ASC_IDLE: begin
            // triggered start while idle
            if (trig_rise) begin
              state      <= ASC_CONV;
              conv_start <= 1'b1;
              seq_active <= 1'b1;
            end
          end
          ASC_CONV: begin
            if (frozen &&
                seq_ctrl[asc_pkg::HALT_SEL_LSB +: 2] == asc_pkg::HALT_NOW)
            begin
              state     <= ASC_HALT;
              conv_hold <= 1'b1;
            end else if (take) begin
              if (last_conv) begin
                pos <= 4'h0;
                if (opts[asc_pkg::OPT_SCAN]) begin
                  conv_start <= 1'b1;
                end else begin
                  state      <= ASC_IDLE;
                  seq_active <= 1'b0;
                end
              end else begin
                pos <= pos + 4'h1;
                conv_start <= 1'b1;
              end
              // finish then freeze: stop before the next conversion
              if (frozen && seq_ctrl[asc_pkg::HALT_SEL_LSB +: 2] ==
                  asc_pkg::HALT_FINISH && state == ASC_CONV &&
                  (!last_conv || opts[asc_pkg::OPT_SCAN])) begin
                state      <= ASC_HALT;
                conv_start <= 1'b0;
              end
            end
          end
          ASC_HALT: begin
            // leave the freeze; resume or begin the next conversion
            if (!frozen) begin
              state     <= ASC_CONV;
              conv_hold <= 1'b0;
              if (!conv_hold) begin
                conv_start <= 1'b1;
              end
            end
          end
          default: begin
            state <= ASC_IDLE;
          end
        endcase
      end
    end
  end

  // result slot counter
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      slot        <= 3'h0;
      result_slot <= 3'h0;
    end else begin
      if (wr_ctl) begin
        slot        <= 3'h0;
        result_slot <= 3'h0;
      end else if (take) begin
        if (last_conv && !seq_ctrl[asc_pkg::RING_BIT]) begin
          // fixed mode restarts at the first register
          slot        <= 3'h0;
          result_slot <= 3'h0;
        end else begin
          // ring mode keeps counting and wraps naturally at the end
          slot        <= slot + 3'h1;
          result_slot <= slot + 3'h1;
        end
      end
    end
  end

  // result file store
  always_ff @(posedge mclk) begin
    if (take) begin
      result_mem[slot] <= conv_data;
    end
  end

  // per-slot done flags and their clearing
  generate
    for (genvar i = 0; i < NUM_RESULTS; i++) begin : g_flag
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          done_flag[i] <= 1'b0;
          stat_seen[i] <= 1'b0;
        end else begin
          if (take && slot == 3'(i)) begin
            done_flag[i] <= 1'b1;
            stat_seen[i] <= 1'b0;
          end else if (res_acc && res_idx == 3'(i) &&
                       (opts[asc_pkg::OPT_QUICK] || stat_seen[i])) begin
            done_flag[i] <= 1'b0;
            stat_seen[i] <= 1'b0;
          end else if (rd && addr == {1'b0, asc_pkg::ADDR_FLAGS}) begin
            stat_seen[i] <= done_flag[i];
          end
        end
      end
    end
  endgenerate

  // sequence complete flag, cleared by any write to 0x2 to 0x5, not by a triggered start
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      scf <= 1'b0;
    end else if (last_conv && !wr_ctl) begin
      scf <= 1'b1;
    end else if (wr_ctl) begin
      scf <= 1'b0;
    end
  end

  // events for the interrupt status
  always_comb begin
    ev_set = '0;
    ev_set[asc_pkg::EV_SEQ_DONE] = last_conv;
    ev_set[asc_pkg::EV_ABORT]    = wr_ctl && state != ASC_IDLE;
    ev_set[asc_pkg::EV_OVERRUN]  = take && done_flag[slot];
  end

  // sticky status, write one to clear, set wins
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ev_stat <= '0;
      ev_mask <= '0;
    end else begin
      if (wr && addr == {1'b0, asc_pkg::ADDR_IRQ_MASK}) begin
        ev_mask <= wdata[EV_NUM_W-1:0];
      end
      if (wr && addr == {1'b0, asc_pkg::ADDR_IRQ_STAT}) begin
        ev_stat <= (ev_stat & ~wdata[EV_NUM_W-1:0]) | ev_set;
      end else begin
        ev_stat <= ev_stat | ev_set;
      end
    end
  end

  // interrupt output from a flop
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ev_stat & ev_mask);
    end
  end

  // read data, one cycle after the read strobe, zero otherwise
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (!rd) begin
      rdata <= 8'h00;
    end else if (addr[4]) begin
      rdata <= result_mem[res_idx][RES_W-1 -: 8];
    end else begin
      case (addr[3:0])
        asc_pkg::ADDR_SEQ_CTRL: rdata <= {1'b0, seq_ctrl};
        asc_pkg::ADDR_STATUS0:  rdata <= {scf, 4'h0, slot};
        asc_pkg::ADDR_FLAGS:    rdata <= done_flag;
        asc_pkg::ADDR_IRQ_STAT: rdata <= {5'h00, ev_stat};
        asc_pkg::ADDR_IRQ_MASK: rdata <= {5'h00, ev_mask};
        asc_pkg::ADDR_OPTS:     rdata <= {6'h00, opts};
        default:                rdata <= 8'h00;
      endcase
    end
  end
endmodule

// ==== tb/asc_seq_asserts.sv ====
`timescale 1ns/1ps
// port-level checks; shadows the control register from the bus
module asc_seq_asserts (
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       debug_freeze,
  input wire logic       conv_start,
  input wire logic       conv_abort,
  input wire logic       conv_hold,
  input wire logic       conv_done,
  input wire logic [2:0] result_slot,
  input wire logic       seq_active
);
  logic [6:0] ctl;   // shadow of the control register
  logic       ab_wr; // write to a control register that aborts
  assign ab_wr = wr && addr >= 5'h02 && addr <= 5'h05;
  // shadow follows writes to the control register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) ctl <= 7'h20;
    else if (wr && addr == 5'h03) ctl <= wdata[6:0];
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_read_idle_zero: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  a_bit7_zero: assert property (
    rd && addr == 5'h03 |=> rdata[7] == 1'b0)
    else $error("control bit 7 not zero");
  a_abort_on_write: assert property (
    ab_wr && seq_active |=> conv_abort)
    else $error("no abort on control write");
  a_write_quiet: assert property (
    ab_wr && addr != 5'h05 |=> !seq_active && !conv_start)
    else $error("control write started work");
  a_slot_cleared: assert property (
    ab_wr |=> result_slot == 3'h0)
    else $error("slot not cleared");
  a_start_write: assert property (
    wr && addr == 5'h05 |=> conv_start && result_slot == 3'h0)
    else $error("start write misbehaved");
  a_ring_step: assert property (
    ctl[2] && conv_done && seq_active && !ab_wr
    |=> result_slot == $past(result_slot) + 3'h1)
    else $error("ring slot did not step");
  a_halt_now: assert property (
    (ctl[1:0] == 2'h3 && seq_active && debug_freeze)[*5] |-> conv_hold)
    else $error("no hold on freeze");
  a_no_hold: assert property (
    ctl[1:0] != 2'h3 |-> !conv_hold)
    else $error("hold outside halt-now");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start longer than a pulse");
  c_abort: cover property (conv_abort);
  c_hold: cover property (conv_hold);
  c_wrap: cover property (result_slot == 3'h7 ##1 result_slot == 3'h0);
endmodule

bind asc_seq_ctrl asc_seq_asserts u_chk (.mclk, .rstn, .addr, .wdata,
  .wr, .rd, .rdata, .debug_freeze, .conv_start, .conv_abort,
  .conv_hold, .conv_done, .result_slot, .seq_active);

// ==== tb/asc_core_model.sv ====
`timescale 1ns/1ps
// converter core: one result per start after DELAY cycles
module asc_core_model #(
  parameter int DELAY = 8  // cycles per conversion
) (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       conv_start,
  input  wire logic       conv_abort,
  input  wire logic       conv_hold,
  output logic            conv_done,
  output logic      [9:0] conv_data
);
  logic       busy; // conversion in flight
  logic [3:0] tmr;  // cycles left
  logic [7:0] cnt;  // results delivered so far
  logic [9:0] dat;  // result being handed over
  // timer frozen while held, dropped on abort
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      tmr <= 4'h0;
      cnt <= 8'h00;
      dat <= 10'h000;
      conv_done <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      if (conv_abort) busy <= 1'b0;
      else if (conv_start) begin
        busy <= 1'b1;
        tmr <= 4'(DELAY - 1);
      end else if (busy && !conv_hold) begin
        if (tmr == 4'h0) begin
          busy <= 1'b0;
          conv_done <= 1'b1;
          dat <= {cnt, 2'b11};
          cnt <= cnt + 8'h01;
        end else tmr <= tmr - 4'h1;
      end
    end
  end
  // data valid only with the pulse, garbage otherwise
  assign conv_data = conv_done ? dat : ~dat;
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic       mclk, rstn, wr, rd, debug_freeze, ext_trig, ia;
  logic [4:0] addr;
  logic [7:0] wdata, rdata;
  logic       conv_start, conv_abort, conv_hold, conv_done;
  logic       seq_active, irq;
  logic [9:0] conv_data;
  logic [2:0] result_slot;
  int         errors, cmp_count, starts, dones, i, b;
  asc_seq_ctrl dut (.mclk, .rstn, .addr, .wdata, .wr, .rd, .rdata,
    .debug_freeze, .ext_trig, .conv_start, .conv_abort, .conv_hold,
    .conv_done, .conv_data, .result_slot, .seq_active, .irq);
  asc_core_model core (.mclk, .rstn, .conv_start, .conv_abort,
    .conv_hold, .conv_done, .conv_data);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // counts conversions begun and finished
  always @(posedge mclk) begin
    if (conv_start === 1'b1) starts++;
    if (conv_done === 1'b1) dones++;
  end
  task check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      errors++;
    end
  endtask
  task wreg(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task rchk(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 check(rdata & m, e);
  endtask
  task run_seq(input logic [7:0] ctl);
    int n;
    wreg(5'h03, ctl);
    wreg(5'h05, 8'h00);
    #1 n = 0;
    while (seq_active !== 1'b0 && n < 500) begin
      @(posedge mclk);
      #1 n++;
    end
    check(8'(n < 500), 8'h01);
  endtask
  task give_verdict;
    if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    give_verdict();
  end
  initial begin
    {rstn, wr, rd, debug_freeze, ext_trig} = 5'h0;
    {addr, wdata, errors, cmp_count, starts, dones} = '0;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    rchk(5'h03, 8'h20, 8'hff);
    wreg(5'h03, 8'hff);
    rchk(5'h03, 8'h7f, 8'hff);
    // fixed order, flags normal then quick clear
    b = dones;
    run_seq(8'h20);
    rchk(5'h08, 8'h0f, 8'hff);
    rchk(5'h10, 8'(b), 8'hff);
    rchk(5'h08, 8'h0e, 8'hff);
    wreg(5'h0b, 8'h02);
    for (i = 1; i < 4; i++) rchk(5'h10 + 5'(i), 8'(b + i), 8'hff);
    rchk(5'h08, 8'h00, 8'hff);
    // every length code
    wreg(5'h0b, 8'h00);
    for (i = 0; i < 16; i++) begin
      b = starts;
      run_seq(8'(i << 3));
      check(8'(starts - b), (i == 0 || i > 7) ? 8'h08 : 8'(i));
    end
    // interrupt raised, masked, cleared
    wreg(5'h09, 8'hff);
    run_seq(8'h08);
    rchk(5'h09, 8'h01, 8'h01);
    wreg(5'h0a, 8'h07);
    repeat (2) @(posedge mclk);
    #1 ia = irq;
    wreg(5'h0a, 8'h00);
    repeat (2) @(posedge mclk);
    #1 check(8'(ia ^ irq), 8'h01);
    wreg(5'h09, 8'h01);
    rchk(5'h09, 8'h00, 8'h01);
    #1 check(8'(irq), 8'h00);
    // ring with scanning: wrap, status, abort
    wreg(5'h0b, 8'h01);
    wreg(5'h03, 8'h1c);
    b = dones;
    wreg(5'h05, 8'h00);
    for (i = 0; i < 500 && dones < b + 10; i++) @(posedge mclk);
    rchk(5'h06, 8'h02, 8'h07);
    rchk(5'h11, 8'(b + 9), 8'hff);
    wreg(5'h03, 8'h1c);
    #1 check({seq_active, 4'h0, result_slot}, 8'h00);
    b = starts;
    repeat (20) @(posedge mclk);
    check(8'(starts - b), 8'h00);
    wreg(5'h0b, 8'h00);
    b = dones;
    run_seq(8'h0c);
    rchk(5'h10, 8'(b), 8'hff);
    // each freeze reaction
    for (i = 0; i < 4; i++) begin
      wreg(5'h03, 8'(i));
      wreg(5'h05, 8'h00);
      debug_freeze <= 1'b1;
      repeat (6) @(posedge mclk);
      #1 b = starts;
      repeat (40) @(posedge mclk);
      #1 check({conv_hold, 1'(starts != b)}, {i == 3, i < 2});
      debug_freeze <= 1'b0;
      repeat (6) @(posedge mclk);
      wreg(5'h03, 8'h00);
    end
    // external trigger rise while idle starts one length-1 sequence
    wreg(5'h03, 8'h08);
    b = starts;
    ext_trig <= 1'b1;
    repeat (20) @(posedge mclk);
    #1 check(8'(starts - b), 8'h01);
    give_verdict();
  end
endmodule
